// file: src/appl_defines.vh
// register map, reset values and timing constants for the axis position loop
// How it works
// - scale register holds any signed 16-bit value; default set per transducer type.
// - a scale of zero acts as 32768, one count per position unit.
// - scale -32768 maps counts to position units one-to-one, reversed.
// - quadrature axes scale the count change and add it to position.
// - offset spans -65536..65535, default zero, unused on quadrature axes.
// - commands above the extend limit become the limit and flag parameter error.
// - commands below the retract limit become the limit and flag parameter error.
// - with negative scale the extend limit is the lower bound.
// - extending means rising transducer counts, retracting means falling counts.
// - limits start at current position; motion waits for new limits and apply.
// - error is target minus actual; proportional drive is gain times error over 10.
// - error clamped to 100000 over gain, overdrive flagged when clamped.
// - proportional and integral gains span 0..65535, default 1.
// - position error is added to the integral accumulator every millisecond.
// - integral drive is integral gain times accumulated error over 10240.
// - differential drive is gain times error change per millisecond over 10.
// - differential gain spans 0..65535, default zero.
// - summed drive, after clamping to 10000, shrinks by feed forward ratio in weaker direction.
`ifndef APPL_DEFINES_VH
`define APPL_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define APPL_CTRL 8'h00
`define APPL_SCALE 8'h04
`define APPL_OFFSET 8'h08
`define APPL_EXT_LIM 8'h0C
`define APPL_RET_LIM 8'h10
`define APPL_PGAIN 8'h14
`define APPL_IGAIN 8'h18
`define APPL_DGAIN 8'h1C
`define APPL_EXT_FF 8'h20
`define APPL_RET_FF 8'h24
`define APPL_ILIM 8'h28
`define APPL_CMD 8'h2C
`define APPL_STATUS 8'h30
`define APPL_ACTPOS 8'h34
`define APPL_TARGET 8'h38
`define APPL_DRIVE 8'h3C

// ----------------------------------------
// field positions
// ----------------------------------------
`define APPL_CTRL_LOOP2 0
`define APPL_CTRL_QUAD 1
`define APPL_CTRL_PRE_LO 2
`define APPL_CTRL_PRE_HI 3
`define APPL_CTRL_APPLY 4
`define APPL_ST_PERR 0
`define APPL_ST_OVDR 1
`define APPL_ST_VALID 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define APPL_SCALE_RST 16'h0000
`define APPL_OFFSET_RST 17'h00000
`define APPL_PGAIN_RST 16'h0001
`define APPL_IGAIN_RST 16'h0001
`define APPL_DGAIN_RST 16'h0000
`define APPL_FF_RST 16'h0064
`define APPL_ILIM_RST 16'h2710

// ----------------------------------------
// arithmetic constants and timing
// ----------------------------------------
`define APPL_UNITY 17'h08000
`define APPL_ELIM_NUM 48'h0000000186A0
`define APPL_PD_DIV 32'h0000000A
`define APPL_I_DIV 32'h00002800
`define APPL_DRIVE_MAX 32'h00002710
`define APPL_ACC_MAX 34'h03FFFFFFF
`define APPL_CLK_NS 4
`define APPL_MS_NS 1000000

`endif

// file: src/appl_div.v
// sequential restoring divider, one quotient bit per clock
`timescale 1ns/100ps
`default_nettype none
module appl_div #(
	parameter NW = 48,
	parameter DW = 32,
	parameter CW = 7
) (
	input wire clk_sys, // system clock
	input wire rst_n, // synchronised reset, low active
	input wire start, // one-cycle start pulse
	input wire [NW-1:0] num, // dividend
	input wire [DW-1:0] den, // divisor, zero gives all ones
	output reg done, // one-cycle pulse with result
	output reg [NW-1:0] quo // quotient
);
	reg [DW:0] rem;
	reg [CW-1:0] cnt;
	reg busy;
	wire [DW:0] rs = {rem[DW-1:0], quo[NW-1]};
	wire take = rs >= {1'b0, den};

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			quo <= {NW{1'b0}};
			rem <= {(DW+1){1'b0}};
			cnt <= {CW{1'b0}};
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				quo <= num;
				rem <= {(DW+1){1'b0}};
				cnt <= NW[CW-1:0];
				busy <= 1'b1;
			end else if (busy) begin
				rem <= take ? rs - {1'b0, den} : rs;
				quo <= {quo[NW-2:0], take};
				cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
				if (cnt == {{(CW-1){1'b0}}, 1'b1}) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule // appl_div
`default_nettype wire

// file: src/appl_top.v
// axis position loop: count scaling, command limits, PID drive, APB registers
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "appl_defines.vh"
module appl_top #(
	parameter [15:0] SCALE_DEFAULT = `APPL_SCALE_RST,
	parameter MS_CYCLES = `APPL_MS_NS / `APPL_CLK_NS
) (
	input wire clk_sys, // 250 MHz clock
	input wire rst_b, // async reset, low active
	input wire [7:0] paddr, // APB address
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB write
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error, unmapped address
	input wire [15:0] transducer_counts, // feedback counts from pins
	output reg [15:0] drive_mv, // signed drive in millivolts
	output reg param_error, // sticky parameter error
	output reg overdrive // sticky overdrive
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_CALC = 4'b0010;
	localparam ST_WAIT = 4'b0100;
	localparam ST_OUT = 4'b1000;

	function [31:0] mag;
		input [31:0] v;
		begin
			mag = v[31] ? (~v + 32'h00000001) : v;
		end
	endfunction

	function [31:0] umin;
		input [31:0] a;
		input [31:0] b;
		begin
			umin = (a < b) ? a : b;
		end
	endfunction

	// ----------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------
	reg rst_q1, rst_n;
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	reg [15:0] cnt_s1, cnt_s2;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_s1 <= 16'h0000;
			cnt_s2 <= 16'h0000;
		end else begin
			cnt_s1 <= transducer_counts;
			cnt_s2 <= cnt_s1;
		end
	end

	// ----------------------------------------
	// millisecond and loop ticks
	// ----------------------------------------
	reg [31:0] ms_cnt;
	reg ms_tick, ms_phase;
	reg loop2;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt <= 32'h00000000;
			ms_tick <= 1'b0;
			ms_phase <= 1'b0;
		end else begin
			ms_tick <= (ms_cnt == MS_CYCLES - 1);
			ms_cnt <= (ms_cnt == MS_CYCLES - 1) ? 32'h00000000 : ms_cnt + 32'h00000001;
			if (ms_tick)
				ms_phase <= ~ms_phase;
		end
	end
	wire loop_tick = ms_tick & (~loop2 | ms_phase);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg quad, apply_seen, lim_written, valid, first;
	reg [1:0] prescale;
	reg [15:0] scale, ext_lim, ret_lim, pgain, igain, dgain, ext_ff, ret_ff, ilim;
	reg signed [16:0] offset;
	reg signed [31:0] actpos, target, e0, e1, acc;
	reg [15:0] cnt_prev;
	reg [3:0] state;
	reg [2:0] step;
	reg [31:0] elim, p_mag, i_mag, d_mag;

	// ----------------------------------------
	// counts to position
	// ----------------------------------------
	wire signed [16:0] scale_eff = (scale == 16'h0000) ? `APPL_UNITY : {scale[15], scale};
	wire scale_neg = scale[15];
	wire [15:0] pre_abs = cnt_s2 >> prescale;
	wire signed [15:0] dcnt = cnt_s2 - cnt_prev;
	wire signed [15:0] pre_d = dcnt >>> prescale;
	wire signed [16:0] pre_sel = quad ? {pre_d[15], pre_d} : {1'b0, pre_abs};
	wire signed [33:0] prod = pre_sel * scale_eff;
	wire signed [33:0] shifted = prod >>> 15;
	wire signed [31:0] off_ext = {{15{offset[16]}}, offset};
	wire signed [31:0] next_pos = quad ? actpos + shifted[31:0]
		: shifted[31:0] + off_ext;

	// ----------------------------------------
	// command limit check
	// ----------------------------------------
	wire signed [31:0] lim_e = {{16{ext_lim[15]}}, ext_lim};
	wire signed [31:0] lim_r = {{16{ret_lim[15]}}, ret_lim};
	wire signed [31:0] lim_hi = scale_neg ? lim_r : lim_e;
	wire signed [31:0] lim_lo = scale_neg ? lim_e : lim_r;
	wire signed [31:0] cmd = {{16{pwdata[15]}}, pwdata[15:0]};
	wire cmd_hi = cmd > lim_hi;
	wire cmd_lo = cmd < lim_lo;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pwrite & pready;
	wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `APPL_DRIVE);
	wire clamp_evt = wr_en & (paddr == `APPL_CMD) & (cmd_hi | cmd_lo);
	wire perr_clr = wr_en & (paddr == `APPL_STATUS) & pwdata[`APPL_ST_PERR];
	wire ovdr_clr = wr_en & (paddr == `APPL_STATUS) & pwdata[`APPL_ST_OVDR];
	reg ovdr_evt;

	reg [31:0] rd_mux;
	always @* begin
		case (paddr)
			`APPL_CTRL: rd_mux = {28'h0000000, prescale, quad, loop2};
			`APPL_SCALE: rd_mux = {16'h0000, scale};
			`APPL_OFFSET: rd_mux = {{15{offset[16]}}, offset};
			`APPL_EXT_LIM: rd_mux = {16'h0000, ext_lim};
			`APPL_RET_LIM: rd_mux = {16'h0000, ret_lim};
			`APPL_PGAIN: rd_mux = {16'h0000, pgain};
			`APPL_IGAIN: rd_mux = {16'h0000, igain};
			`APPL_DGAIN: rd_mux = {16'h0000, dgain};
			`APPL_EXT_FF: rd_mux = {16'h0000, ext_ff};
			`APPL_RET_FF: rd_mux = {16'h0000, ret_ff};
			`APPL_ILIM: rd_mux = {16'h0000, ilim};
			`APPL_STATUS: rd_mux = {29'h00000000, valid, overdrive, param_error};
			`APPL_ACTPOS: rd_mux = actpos;
			`APPL_TARGET: rd_mux = target;
			`APPL_DRIVE: rd_mux = {16'h0000, drive_mv};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			param_error <= 1'b0;
			overdrive <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= mapped ? rd_mux : 32'h00000000;
				pslverr <= ~mapped;
			end
			param_error <= clamp_evt | (param_error & ~perr_clr);
			overdrive <= ovdr_evt | (overdrive & ~ovdr_clr);
		end
	end

	// ----------------------------------------
	// parameter writes and loop sequencer
	// ----------------------------------------
	wire signed [31:0] de_raw = e0 - e1;
	wire signed [31:0] de = de_raw >>> loop2;
	wire signed [31:0] s_p = e0[31] ? -$signed(umin(p_mag, `APPL_DRIVE_MAX)) : $signed(umin(p_mag, `APPL_DRIVE_MAX));
	wire [31:0] i_cl = umin(i_mag, {16'h0000, ilim});
	wire signed [31:0] s_i = acc[31] ? -$signed(i_cl) : $signed(i_cl);
	wire signed [31:0] s_d = de[31] ? -$signed(umin(d_mag, `APPL_DRIVE_MAX)) : $signed(umin(d_mag, `APPL_DRIVE_MAX));
	wire signed [31:0] sum = s_p + s_i + s_d;
	wire [31:0] sum_sat = umin(mag(sum), `APPL_DRIVE_MAX);
	wire dir_ext = sum[31] ~^ scale_neg;
	wire [15:0] ff_dir = dir_ext ? ext_ff : ret_ff;
	wire [15:0] ff_hi = (ext_ff > ret_ff) ? ext_ff : ret_ff;
	wire [31:0] e_mag = mag(e0);
	wire [31:0] pe_lim = umin(e_mag, elim);

	reg [47:0] div_num;
	reg [31:0] div_den;
	always @* begin
		case (step)
			3'd0: begin
				div_num = `APPL_ELIM_NUM;
				div_den = {16'h0000, pgain};
			end
			3'd1: begin
				div_num = pe_lim * pgain;
				div_den = `APPL_PD_DIV;
			end
			3'd2: begin
				div_num = mag(acc) * igain;
				div_den = `APPL_I_DIV;
			end
			3'd3: begin
				div_num = mag(de) * dgain;
				div_den = `APPL_PD_DIV;
			end
			default: begin
				div_num = (ff_hi == 16'h0000) ? {16'h0000, sum_sat} : sum_sat * ff_dir;
				div_den = (ff_hi == 16'h0000) ? 32'h00000001 : {16'h0000, ff_hi};
			end
		endcase
	end

	reg div_start;
	wire div_done;
	wire [47:0] div_quo;
	appl_div #(.NW(48), .DW(32), .CW(7)) u_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(div_start),
		.num(div_num),
		.den(div_den),
		.done(div_done),
		.quo(div_quo)
	);
	wire [31:0] quo_sat = (|div_quo[47:32]) ? 32'hFFFFFFFF : div_quo[31:0];

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			loop2 <= 1'b0;
			quad <= 1'b0;
			prescale <= 2'b00;
			scale <= SCALE_DEFAULT;
			offset <= `APPL_OFFSET_RST;
			ext_lim <= 16'h0000;
			ret_lim <= 16'h0000;
			pgain <= `APPL_PGAIN_RST;
			igain <= `APPL_IGAIN_RST;
			dgain <= `APPL_DGAIN_RST;
			ext_ff <= `APPL_FF_RST;
			ret_ff <= `APPL_FF_RST;
			ilim <= `APPL_ILIM_RST;
			target <= 32'h00000000;
			actpos <= 32'h00000000;
			cnt_prev <= 16'h0000;
			e0 <= 32'h00000000;
			e1 <= 32'h00000000;
			elim <= 32'h00000000;
			p_mag <= 32'h00000000;
			i_mag <= 32'h00000000;
			d_mag <= 32'h00000000;
			lim_written <= 1'b0;
			apply_seen <= 1'b0;
			valid <= 1'b0;
			first <= 1'b1;
			state <= ST_IDLE;
			step <= 3'd0;
			div_start <= 1'b0;
			ovdr_evt <= 1'b0;
			drive_mv <= 16'h0000;
		end else begin
			div_start <= 1'b0;
			ovdr_evt <= 1'b0;
			apply_seen <= 1'b0;
			if (wr_en) begin
				case (paddr)
					`APPL_CTRL: begin
						loop2 <= pwdata[`APPL_CTRL_LOOP2];
						quad <= pwdata[`APPL_CTRL_QUAD];
						prescale <= pwdata[`APPL_CTRL_PRE_HI:`APPL_CTRL_PRE_LO];
						apply_seen <= pwdata[`APPL_CTRL_APPLY];
					end
					`APPL_SCALE: scale <= pwdata[15:0];
					`APPL_OFFSET: offset <= pwdata[16:0];
					`APPL_EXT_LIM: begin
						ext_lim <= pwdata[15:0];
						lim_written <= 1'b1;
					end
					`APPL_RET_LIM: begin
						ret_lim <= pwdata[15:0];
						lim_written <= 1'b1;
					end
					`APPL_PGAIN: pgain <= pwdata[15:0];
					`APPL_IGAIN: igain <= pwdata[15:0];
					`APPL_DGAIN: dgain <= pwdata[15:0];
					`APPL_EXT_FF: ext_ff <= pwdata[15:0];
					`APPL_RET_FF: ret_ff <= pwdata[15:0];
					`APPL_ILIM: ilim <= pwdata[15:0];
					`APPL_CMD: target <= cmd_hi ? lim_hi : (cmd_lo ? lim_lo : cmd);
					default: ;
				endcase
			end
			if (apply_seen & lim_written)
				valid <= 1'b1;
			case (state)
				ST_IDLE: begin
					if (loop_tick) begin
						actpos <= next_pos;
						cnt_prev <= cnt_s2;
						e1 <= e0;
						if (first) begin
							ext_lim <= next_pos[15:0];
							ret_lim <= next_pos[15:0];
							target <= next_pos;
							e0 <= 32'h00000000;
							first <= 1'b0;
						end else begin
							e0 <= target - next_pos;
						end
						step <= 3'd0;
						state <= ST_CALC;
					end
				end
				ST_CALC: begin
					div_start <= 1'b1;
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					if (div_done) begin
						case (step)
							3'd0: begin
								elim <= quo_sat;
								ovdr_evt <= valid & (pgain != 16'h0000) & (e_mag > quo_sat);
							end
							3'd1: p_mag <= quo_sat;
							3'd2: i_mag <= quo_sat;
							3'd3: d_mag <= quo_sat;
							default: ;
						endcase
						step <= step + 3'd1;
						state <= (step == 3'd4) ? ST_OUT : ST_CALC;
						if (step == 3'd4)
							drive_mv <= ~valid ? 16'h0000 : sum[31] ? -quo_sat[15:0] : quo_sat[15:0];
					end
				end
				ST_OUT: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// integral accumulator
	// ----------------------------------------
	wire signed [33:0] acc_sum = {{2{acc[31]}}, acc} + {{2{e0[31]}}, e0};
	wire signed [33:0] acc_max = `APPL_ACC_MAX, acc_min = -acc_max;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			acc <= 32'h00000000;
		end else if (~valid) begin
			acc <= 32'h00000000;
		end else if (ms_tick) begin
			if (acc_sum > acc_max)
				acc <= acc_max[31:0];
			else if (acc_sum < acc_min)
				acc <= acc_min[31:0];
			else
				acc <= acc_sum[31:0];
		end
	end
endmodule // appl_top
`default_nettype wire

// file: sim/appl_valve.sv
// valve amplifier model fed by the loop's drive output
`timescale 1ns/100ps
`default_nettype none
module appl_valve (
	input wire logic clk_sys, // clock
	input wire logic rst_b, // reset, low active
	input wire logic [15:0] drive_mv, // signed drive in mV
	output logic [15:0] spool, // spool opening, lags drive
	output logic over // drive beyond full scale seen
);
	// spool follows drive with a first order lag
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			spool <= 16'h0000;
			over <= 1'b0;
		end else begin
			spool <= spool + 16'((17'($signed(drive_mv)) - 17'($signed(spool))) >>> 3);
			if ($signed(drive_mv) > 16'sh2710 || $signed(drive_mv) < -16'sh2710) begin
				over <= 1'b1;
			end
		end
	end
endmodule // appl_valve
`default_nettype wire

// file: sim/appl_top_monitor.sv
// port-level assertions for the axis position loop
`timescale 1ns/100ps
`default_nettype none
module appl_top_monitor #(
	parameter MS_CYCLES = 250000
) (
	input wire logic clk_sys, // clock
	input wire logic rst_b, // reset, low active
	input wire logic [7:0] paddr, // address
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // write
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic [15:0] transducer_counts, // counts
	input wire logic [15:0] drive_mv, // drive
	input wire logic param_error, // clamp flag
	input wire logic overdrive // overdrive flag
);
	wire logic acc = psel && penable && pready && pwrite;
	int gap;
	logic [3:0] cmd_age;
	logic [15:0] drv_q;
	// ----------------
	// helper counters
	// ----------------
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			gap <= MS_CYCLES;
			cmd_age <= 4'hF;
			drv_q <= 16'h0000;
		end else begin
			drv_q <= drive_mv;
			gap <= (drive_mv != drv_q) ? 1 : (gap < MS_CYCLES) ? gap + 1 : gap;
			cmd_age <= (acc && paddr == 8'h2C) ? 4'h0 : (cmd_age == 4'hF) ? 4'hF : cmd_age + 4'h1;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
		else $error("ready outside access");
	a_err_on_unmapped: assert property (psel && !penable |=> pslverr == $past(paddr[1:0] != 2'b00 || paddr > 8'h3C))
		else $error("error flag wrong");
	a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000) else $error("bad read");
	a_drive_in_range: assert property ($signed(drive_mv) <= 16'sh2710 && $signed(drive_mv) >= -16'sh2710)
		else $error("drive out of range");
	a_perr_clear_cause: assert property ($fell(param_error) |-> $past(acc && paddr == 8'h30 && pwdata[0]))
		else $error("clamp flag lost");
	a_ovdr_clear_cause: assert property ($fell(overdrive) |-> $past(acc && paddr == 8'h30 && pwdata[1]))
		else $error("overdrive flag lost");
	a_perr_set_cause: assert property ($rose(param_error) |-> cmd_age != 4'hF)
		else $error("clamp flag without command");
	a_drive_loop_gap: assert property (drive_mv != drv_q |-> gap >= MS_CYCLES - 8)
		else $error("drive changed within a loop");
	a_reset_quiet: assert property ($rose(rst_b) |-> (drive_mv == 16'h0000 && !param_error && !overdrive) [*2])
		else $error("outputs busy after reset");
endmodule // appl_top_monitor
`default_nettype wire

// file: sim/tb_axis_position_pid_loop.sv
// self-checking bench for the axis position loop
`timescale 1ns/100ps
`default_nettype none
module tb_axis_position_pid_loop;
	localparam int MS = 400;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [15:0] transducer_counts = 16'h0000;
	wire logic [31:0] prdata;
	wire logic [15:0] drive_mv;
	wire logic [15:0] spool;
	wire logic pready, pslverr, param_error, overdrive, valve_over;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int cnt, off, p0, lo, hi, cmd, ex;
	logic [15:0] sc;
	logic [31:0] seed = 32'h8E4D0252;
	logic [31:0] rd_v;
	logic rd_e;
	logic [39:0] rtab [0:9] = '{40'h0400000000, 40'h0800000000, 40'h1400000001, 40'h1800000001, 40'h1C00000000,
		40'h2000000064, 40'h2400000064, 40'h2800002710, 40'h3000000000, 40'h2C00000000};
	int ptab [0:3][0:1] = '{'{1050, 100}, '{1050, 50}, '{2500, 100}, '{0, 100}};

	appl_top #(.MS_CYCLES(MS)) dut (.clk_sys, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .transducer_counts, .drive_mv, .param_error, .overdrive);
	appl_valve u_valve (.clk_sys, .rst_b, .drive_mv, .spool, .over(valve_over));

	initial begin
		forever #2 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic int pos(input int c, input logic [15:0] s, input int pr);
		return ((c >> pr) * ((s == 16'h0000) ? 32768 : int'($signed(s)))) >>> 15;
	endfunction

	function automatic logic [31:0] sx(input logic [15:0] d);
		return {{16{d[15]}}, d};
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %0h expected %0h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd_v = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(pready, 1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk(rd_v, e);
	endtask

	task automatic wl();
		repeat (2 * MS) @(posedge clk_sys);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			$display("[FAIL] %0t timeout", $time);
			end_sim();
		end
	end

	// ----------------
	// test sequence
	// ----------------
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int i = 0; i < 10; i++) rdc(rtab[i][39:32], rtab[i][31:0]);
		rdc(8'h40, 0);
		chk(rd_e, 1);
		rdc(8'h06, 0);
		chk(rd_e, 1);
		$display("test 1 reset values done");
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			sc = (i == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : (i == 2) ? 16'h4000 : seed[31:16];
			cnt = seed[11:0];
			off = int'(seed[21:12]) - 512;
			transducer_counts <= cnt[15:0];
			wr(8'h00, i << 2);
			wr(8'h04, sc);
			wr(8'h08, off);
			wl();
			rdc(8'h34, pos(cnt, sc, i) + off);
		end
		chk(drive_mv, 0);
		wr(8'h00, 32'h00000002);
		wr(8'h04, 32'h00008000);
		wl();
		apb(1'b0, 8'h34, 32'h00000000);
		p0 = rd_v;
		transducer_counts <= cnt[15:0] + 16'h0064;
		wl();
		rdc(8'h34, p0 - 100);
		$display("test 2 scaling done");
		wr(8'h00, 0);
		wr(8'h08, 0);
		transducer_counts <= 16'h03E8;
		for (int k = 0; k < 2; k++) begin
			lo = k ? -1500 : 500;
			hi = k ? -500 : 1500;
			wr(8'h04, k ? 32'h00008000 : 0);
			wr(8'h0C, k ? lo : hi);
			wr(8'h10, k ? hi : lo);
			wr(8'h00, 32'h00000010);
			for (int j = 0; j < 3; j++) begin
				cmd = (j == 0) ? hi + 400 : (j == 1) ? lo - 400 : lo + 200;
				ex = (cmd > hi) ? hi : (cmd < lo) ? lo : cmd;
				wr(8'h30, 3);
				wr(8'h2C, cmd);
				rdc(8'h38, ex);
				chk(param_error, j < 2);
			end
		end
		$display("test 3 limits done");
		wr(8'h04, 0);
		wr(8'h0C, 30000);
		wr(8'h10, -30000);
		wr(8'h00, 32'h00000010);
		wr(8'h18, 0);
		wr(8'h14, 100);
		for (int j = 0; j < 4; j++) begin
			wr(8'h20, ptab[j][1]);
			wr(8'h2C, ptab[j][0]);
			wl();
			wr(8'h30, 3);
			wl();
			ex = ptab[j][0] - 1000;
			ex = (ex > 1000) ? 1000 : (ex < -1000) ? -1000 : ex;
			ex = ex * 100 / 10;
			if (ex > 0) ex = ex * ptab[j][1] / 100;
			chk(sx(drive_mv), ex);
			chk(overdrive, ptab[j][0] - 1000 > 1000);
			chk(sx(drive_mv) - sx(spool) < 32'd8, 1);
		end
		chk(valve_over, 0);
		$display("test 4 drive done");
		rst_b <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		wl();
		wr(8'h14, 0);
		wr(8'h18, 0);
		wr(8'h1C, 10);
		wr(8'h0C, 30000);
		wr(8'h10, -30000);
		wr(8'h00, 32'h00000011);
		wr(8'h2C, 1100);
		for (int t = 0; t < 1200 && drive_mv == 16'h0000; t++) @(posedge clk_sys);
		chk(sx(drive_mv), 50);
		wl();
		repeat (MS) @(posedge clk_sys);
		chk(drive_mv, 0);
		wr(8'h00, 0);
		wr(8'h18, 1024);
		wl();
		p0 = int'($signed(drive_mv));
		repeat (MS) @(posedge clk_sys);
		chk(sx(drive_mv), p0 + 1024 * 100 / 10240);
		chk(valve_over, 0);
		$display("test 5 reset and loop terms done");
		end_sim();
	end
endmodule // tb_axis_position_pid_loop

bind appl_top appl_top_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.clk_sys, .rst_b, .paddr, .psel, .penable, .pwrite,
	.pwdata, .prdata, .pready, .pslverr, .transducer_counts, .drive_mv, .param_error, .overdrive);
`default_nettype wire
